// file: design/bpt_pkg.sv
// Purpose: Shared constants for the buffered PWM timer block.
// Assumes: AXI4-Lite slave, 32-bit data, byte addresses below 0x80.
// Notes:   Six channels, three linkable pairs, 16-bit counter.
//
// How it works
// - Even buffered bit links pair onto even pin
// - Even values first; odd write takes over later
// - Each overflow selects most recently written value of the pair
// - Odd control unused; odd pin released
// - Mode field 01 unbuffered, 10 buffered
// - Toggle on overflow; compare forces complement level
// - Buffered bit overrides mode low bit
// - No overflow toggle gives zero duty
// - Full duty bit plus toggle holds full duty
// - Overflow flag at modulo; request needs enable
// - Channel flag on compare; gated by enable
// - Wait: runs, registers locked, requests wake
// - Stop: halts, keeps all state
// - Break stops the counter
// - Break clear allowed: clears stick
// - Break clear denied: status unchanged, arming kept
// - Prescale code all ones selects external clock
// - Selected external clock pin forced to input
// - Codes 0..6 divide by 1..64
// - Modulo match restarts; high write inhibits flag
// - Overflow flag cleared by read then write zero
// - Counter reset bit self-clears, reads zero
package bpt_pkg;
  localparam int NUM_CHAN = 6;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_COUNT   = 8'h04;
  localparam logic [7:0] ADDR_MODULO  = 8'h08;
  localparam logic [7:0] ADDR_CH_BASE = 8'h10;
  localparam logic [7:0] ADDR_CH_END  = 8'h3F;
  localparam logic [7:0] CH_VAL_OFS   = 8'h04;
  // Timer control register fields
  localparam int CTRL_WRAP_FLAG = 7;
  localparam int CTRL_WRAP_IE   = 6;
  localparam int CTRL_HALT      = 5;
  localparam int CTRL_CNT_RST   = 4;
  localparam int CTRL_PS_HI     = 2;
  localparam logic [2:0] PS_EXT = 3'h7;
  // Channel control register fields
  localparam int CH_FLAG   = 7;
  localparam int CH_IE     = 6;
  localparam int CH_MS_HI  = 5;
  localparam int CH_MS_LO  = 4;
  localparam int CH_ELS_HI = 3;
  localparam int CH_ELS_LO = 2;
  localparam int CH_TOV    = 1;
  localparam int CH_FULL   = 0;
  // Edge/level encodings
  localparam logic [1:0] ELS_OFF    = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR  = 2'h2;
  localparam logic [1:0] ELS_SET    = 2'h3;
  // Reset values
  localparam logic [7:0]  CTRL_RESET = 8'h20;
  localparam logic [15:0] MOD_RESET  = 16'hFFFF;
  localparam logic [7:0]  CH_RESET   = 8'h00;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int PRESCALE_W = 6;
endpackage

// file: design/bpt_prescale.sv
// Purpose: Counter clock source: divided bus clock or external pin.
// Assumes: External pin synchronous to CLK_SYS, slower than half of it.
// Notes:   Tick is a one-cycle pulse; cleared together with the counter.
`timescale 1ns/1ps
module bpt_prescale (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Control
  input  wire logic       clr,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  input  wire logic       ext_in,
  // Result
  output logic            tick
);
  logic [bpt_pkg::PRESCALE_W-1:0] div_q;
  logic                           ext_q;
  logic [bpt_pkg::PRESCALE_W-1:0] mask;
  logic                           ext_sel;
  logic                           div_hit;
  logic                           ext_rise;

  // Mask of low divider bits; all ones means one tick per wrap
  assign mask     = bpt_pkg::PRESCALE_W'((7'h01 << sel) - 7'h01);
  assign ext_sel  = (sel == bpt_pkg::PS_EXT);
  assign div_hit  = ((div_q & mask) == mask);
  assign ext_rise = ext_in & ~ext_q;

  // Divider and external edge detect; divider frozen while not running
  always_ff @(posedge clk) begin
    if (srst || clr) begin
      div_q <= '0;
      tick  <= 1'b0;
    end else begin
      if (run)
        div_q <= div_q + 1'b1;
      tick <= run & (ext_sel ? ext_rise : div_hit);
    end
  end

  // Edge history runs always so a stale level cannot fake an edge
  always_ff @(posedge clk) begin
    if (srst)
      ext_q <= 1'b0;
    else
      ext_q <= ext_in;
  end
endmodule // bpt_prescale

// file: design/bpt_chan.sv
// Purpose: One output compare / PWM channel output stage.
// Assumes: Compare value already chosen by the buffer logic above.
// Notes:   Toggle on overflow first, then the compare action wins.
`timescale 1ns/1ps
module bpt_chan (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Counter events
  input  wire logic        tick,
  input  wire logic        wrap,
  input  wire logic [15:0] count,
  input  wire logic [15:0] cmp_val,
  // Configuration
  input  wire logic        enable,
  input  wire logic [1:0]  els,
  input  wire logic        tov,
  input  wire logic        full,
  // Results
  output logic             pin_q,
  output logic             oe_q,
  output logic             match
);
  logic after_wrap;
  logic pulse_lvl;

  assign match      = tick & enable & (count == cmp_val);
  assign after_wrap = (wrap & tov & enable) ? ~pin_q : pin_q;
  // Pulse level is the complement of what the compare forces
  assign pulse_lvl  = (els != bpt_pkg::ELS_SET);

  // Output level; a channel with no edge/level action releases its pin
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      oe_q <= enable & (els != bpt_pkg::ELS_OFF);
      if (enable && full && tov)
        pin_q <= pulse_lvl;
      else if (match) begin
        unique case (els)
          bpt_pkg::ELS_TOGGLE: pin_q <= ~after_wrap;
          bpt_pkg::ELS_CLEAR:  pin_q <= 1'b0;
          bpt_pkg::ELS_SET:    pin_q <= 1'b1;
          bpt_pkg::ELS_OFF:    pin_q <= after_wrap;
        endcase
      end else
        pin_q <= after_wrap;
    end
  end
endmodule // bpt_chan

// file: design/bpt_top.sv
// Purpose: Six-channel 16-bit timer with buffered PWM over AXI4-Lite.
// Assumes: One clock; system mode inputs synchronous to CLK_SYS.
// Notes:   One write and one read outstanding; registers in low bytes.
`timescale 1ns/1ps
module bpt_top (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // System state
  input  wire logic        WAIT_MODE,
  input  wire logic        STOP_MODE,
  input  wire logic        BREAK_ACTIVE,
  input  wire logic        BREAK_CLEAR_ALLOW,
  // External count clock pin
  input  wire logic        EXT_COUNT_CLOCK,
  input  wire logic        PORTD6_DIRECTION,
  output logic             EXT_PIN_OE,
  // Channel pins
  output logic [5:0]       CHAN_PIN_OUT,
  output logic [5:0]       CHAN_PIN_OE,
  // Requests
  output logic             WRAP_IRQ,
  output logic [5:0]       CHAN_IRQ,
  output logic             WAKE_REQ
);
  localparam int N = bpt_pkg::NUM_CHAN;

  // Channel index from a byte address inside the channel window
  function automatic logic [2:0] ch_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - bpt_pkg::ADDR_CH_BASE;
    return d[5:3];
  endfunction

  // A channel register address, in range and not beyond the last
  function automatic logic in_ch(input logic [7:0] a);
    return (a >= bpt_pkg::ADDR_CH_BASE) && (a <= bpt_pkg::ADDR_CH_END)
           && (a[1:0] == 2'h0);
  endfunction

  // Registers
  logic [7:0]  ctrl_q;
  logic [15:0] cnt_q;
  logic [15:0] mod_q;
  logic        mod_inhibit_q;
  logic        wrap_arm_q;
  logic [7:0]  ch_ctrl_q [N];
  logic [15:0] ch_val_q  [N];
  logic [N-1:0] ch_arm_q;
  logic [2:0]  active_q;
  logic [2:0]  last_q;
  // Bus state
  logic        awready_q;
  logic        wready_q;
  logic        aw_full_q;
  logic        w_full_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  // Output flops
  logic        ext_oe_q;
  logic        wrap_irq_q;
  logic [N-1:0] chan_irq_q;
  logic        wake_q;

  // Bus decode
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        do_wr;
  logic        wr_ok;
  logic        rd_ok;
  logic        wr_ctrl;
  logic        wr_mod;
  logic        wr_ch;
  logic        wr_is_val;
  logic [2:0]  wr_idx;
  logic        rd_ctrl;
  logic        rd_ch;
  logic        rd_is_val;
  logic [2:0]  rd_idx;
  logic        wr_map;
  logic        rd_map;
  logic [31:0] rd_word;

  assign aw_take   = S_AXI_AWVALID & awready_q;
  assign w_take    = S_AXI_WVALID & wready_q;
  assign ar_take   = S_AXI_ARVALID & arready_q;
  assign do_wr     = aw_full_q & w_full_q & ~bvalid_q;
  assign wr_ctrl   = (awaddr_q == bpt_pkg::ADDR_CTRL);
  assign wr_mod    = (awaddr_q == bpt_pkg::ADDR_MODULO);
  assign wr_ch     = in_ch(awaddr_q);
  assign wr_is_val = awaddr_q[2];
  assign wr_idx    = ch_idx(awaddr_q);
  assign wr_map    = wr_ctrl | wr_mod | wr_ch
                   | (awaddr_q == bpt_pkg::ADDR_COUNT);
  // Registers are locked out while the processor waits
  assign wr_ok     = do_wr & wr_map & ~WAIT_MODE;
  assign rd_ctrl   = (S_AXI_ARADDR == bpt_pkg::ADDR_CTRL);
  assign rd_ch     = in_ch(S_AXI_ARADDR);
  assign rd_is_val = S_AXI_ARADDR[2];
  assign rd_idx    = ch_idx(S_AXI_ARADDR);
  assign rd_map    = rd_ctrl | rd_ch
                   | (S_AXI_ARADDR == bpt_pkg::ADDR_COUNT)
                   | (S_AXI_ARADDR == bpt_pkg::ADDR_MODULO);
  assign rd_ok     = ar_take & rd_map & ~WAIT_MODE;

  // Linking and status-clear permission
  logic [2:0]  linked;
  logic        clr_allowed;
  logic        run;
  logic        cnt_rst;
  logic        tick;
  logic        wrap;
  logic        wrap_set;
  logic [N-1:0] ch_match;
  logic [N-1:0] ch_en;
  logic [15:0] cmp_val [N];
  logic        wr_rst_bit;

  assign linked[0]   = ch_ctrl_q[0][bpt_pkg::CH_MS_HI];
  assign linked[1]   = ch_ctrl_q[2][bpt_pkg::CH_MS_HI];
  assign linked[2]   = ch_ctrl_q[4][bpt_pkg::CH_MS_HI];
  assign clr_allowed = ~BREAK_ACTIVE | BREAK_CLEAR_ALLOW;
  // Counter runs only when not halted, not in stop, not in break
  assign run     = ~ctrl_q[bpt_pkg::CTRL_HALT] & ~STOP_MODE
                 & ~BREAK_ACTIVE;
  assign cnt_rst = wr_ok & wr_ctrl & wr_rst_bit;
  assign wrap     = tick & (cnt_q == mod_q);
  assign wrap_set = wrap & ~mod_inhibit_q;

  // Counter reset bit of the captured write
  assign wr_rst_bit = wstrb_q[0] & wdata_q[bpt_pkg::CTRL_CNT_RST];

  // Per-channel mode and buffered compare source
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      logic [1:0] ms;
      assign ms = {ch_ctrl_q[g][bpt_pkg::CH_MS_HI],
                   ch_ctrl_q[g][bpt_pkg::CH_MS_LO]};
      if (g % 2 == 0) begin : g_even
        // Buffered bit alone is enough; low bit is then a don't care
        assign ch_en[g]   = (ms != 2'h0);
        assign cmp_val[g] = (linked[g/2] && active_q[g/2]) ?
                            ch_val_q[g+1] : ch_val_q[g];
      end else begin : g_odd
        // Odd half of a linked pair has no output function
        assign ch_en[g]   = (ms != 2'h0) & ~linked[g/2];
        assign cmp_val[g] = ch_val_q[g];
      end
      bpt_chan u_chan (
        .clk     (CLK_SYS),
        .srst    (SRST),
        .tick    (tick),
        .wrap    (wrap),
        .count   (cnt_q),
        .cmp_val (cmp_val[g]),
        .enable  (ch_en[g]),
        .els     (ch_ctrl_q[g][bpt_pkg::CH_ELS_HI:bpt_pkg::CH_ELS_LO]),
        .tov     (ch_ctrl_q[g][bpt_pkg::CH_TOV]),
        .full    (ch_ctrl_q[g][bpt_pkg::CH_FULL]),
        .pin_q   (CHAN_PIN_OUT[g]),
        .oe_q    (CHAN_PIN_OE[g]),
        .match   (ch_match[g])
      );
    end
  endgenerate

  // Counter clock source
  bpt_prescale u_prescale (
    .clk    (CLK_SYS),
    .srst   (SRST),
    .clr    (cnt_rst),
    .run    (run),
    .sel    (ctrl_q[bpt_pkg::CTRL_PS_HI:0]),
    .ext_in (EXT_COUNT_CLOCK),
    .tick   (tick)
  );

  // Read data mux; odd control of a linked pair reads as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_ctrl)
      rd_word[7:0] = ctrl_q & ~(8'h01 << bpt_pkg::CTRL_CNT_RST);
    else if (S_AXI_ARADDR == bpt_pkg::ADDR_COUNT)
      rd_word[15:0] = cnt_q;
    else if (S_AXI_ARADDR == bpt_pkg::ADDR_MODULO)
      rd_word[15:0] = mod_q;
    else if (rd_ch && rd_is_val)
      rd_word[15:0] = ch_val_q[rd_idx];
    else if (rd_ch && !(rd_idx[0] && linked[rd_idx[2:1]]))
      rd_word[7:0] = ch_ctrl_q[rd_idx];
  end

  // Write channel handshake: address and data taken in either order
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= bpt_pkg::RESP_OKAY;
    end else begin
      aw_full_q <= aw_take | (aw_full_q & ~do_wr);
      w_full_q  <= w_take | (w_full_q & ~do_wr);
      awready_q <= ~(aw_take | (aw_full_q & ~do_wr));
      wready_q  <= ~(w_take | (w_full_q & ~do_wr));
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? bpt_pkg::RESP_OKAY : bpt_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY)
        bvalid_q <= 1'b0;
    end
  end

  // Captured write payload
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (aw_take)
        awaddr_q <= S_AXI_AWADDR;
      if (w_take) begin
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
    end
  end

  // Read channel: data registered, address refused while answer stands
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= bpt_pkg::RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_ok ? rd_word : 32'h0000_0000;
      rresp_q   <= rd_ok ? bpt_pkg::RESP_OKAY : bpt_pkg::RESP_SLVERR;
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end else if (!rvalid_q)
      arready_q <= 1'b1;
  end

  // Timer control, counter and modulo
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ctrl_q        <= bpt_pkg::CTRL_RESET;
      cnt_q         <= 16'h0000;
      mod_q         <= bpt_pkg::MOD_RESET;
      mod_inhibit_q <= 1'b0;
      wrap_arm_q    <= 1'b0;
    end else begin
      if (cnt_rst)
        cnt_q <= 16'h0000;
      else if (tick)
        cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
      // Arming needs the flag set; a denied break read does not arm
      if (wrap_set)
        wrap_arm_q <= 1'b0;
      else if (rd_ok && rd_ctrl && ctrl_q[bpt_pkg::CTRL_WRAP_FLAG]
               && clr_allowed)
        wrap_arm_q <= 1'b1;
      if (wr_ok && wr_ctrl && wstrb_q[0]) begin
        ctrl_q[bpt_pkg::CTRL_WRAP_IE:0] <=
          wdata_q[bpt_pkg::CTRL_WRAP_IE:0] &
          ~(7'h01 << bpt_pkg::CTRL_CNT_RST);
      end
      // New overflow beats a clear in the same cycle
      if (wrap_set)
        ctrl_q[bpt_pkg::CTRL_WRAP_FLAG] <= 1'b1;
      else if (wr_ok && wr_ctrl && wstrb_q[0] && wrap_arm_q
               && !wdata_q[bpt_pkg::CTRL_WRAP_FLAG] && clr_allowed) begin
        ctrl_q[bpt_pkg::CTRL_WRAP_FLAG] <= 1'b0;
        wrap_arm_q <= 1'b0;
      end
      if (wr_ok && wr_mod) begin
        if (wstrb_q[1])
          mod_q[15:8] <= wdata_q[15:8];
        if (wstrb_q[0])
          mod_q[7:0] <= wdata_q[7:0];
        // High byte alone holds off flagging until low byte arrives
        mod_inhibit_q <= wstrb_q[1] & ~wstrb_q[0];
      end
    end
  end

  // Channel registers, flags and pair selection
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      for (int i = 0; i < N; i++) begin
        ch_ctrl_q[i] <= bpt_pkg::CH_RESET;
        ch_val_q[i]  <= 16'h0000;
      end
      ch_arm_q <= '0;
      active_q <= 3'h0;
      last_q   <= 3'h0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (wr_ok && wr_ch && wr_idx == 3'(i) && wr_is_val) begin
          if (wstrb_q[1])
            ch_val_q[i][15:8] <= wdata_q[15:8];
          if (wstrb_q[0])
            ch_val_q[i][7:0] <= wdata_q[7:0];
        end
        if (wr_ok && wr_ch && wr_idx == 3'(i) && !wr_is_val
            && wstrb_q[0] && !(i % 2 == 1 && linked[i/2]))
          ch_ctrl_q[i][bpt_pkg::CH_IE:0] <= wdata_q[bpt_pkg::CH_IE:0];
        if (ch_match[i])
          ch_arm_q[i] <= 1'b0;
        else if (rd_ok && rd_ch && !rd_is_val && rd_idx == 3'(i)
                 && ch_ctrl_q[i][bpt_pkg::CH_FLAG] && clr_allowed)
          ch_arm_q[i] <= 1'b1;
        if (ch_match[i])
          ch_ctrl_q[i][bpt_pkg::CH_FLAG] <= 1'b1;
        else if (wr_ok && wr_ch && !wr_is_val && wr_idx == 3'(i)
                 && wstrb_q[0] && ch_arm_q[i] && clr_allowed
                 && !wdata_q[bpt_pkg::CH_FLAG]) begin
          ch_ctrl_q[i][bpt_pkg::CH_FLAG] <= 1'b0;
          ch_arm_q[i] <= 1'b0;
        end
      end
      for (int p = 0; p < N / 2; p++) begin
        if (!linked[p]) begin
          active_q[p] <= 1'b0;
          last_q[p]   <= 1'b0;
        end else begin
          if (wr_ok && wr_ch && wr_is_val && wr_idx[2:1] == 2'(p))
            last_q[p] <= wr_idx[0];
          if (wrap)
            active_q[p] <= last_q[p];
        end
      end
    end
  end

  // Requests and pin direction
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ext_oe_q   <= 1'b0;
      wrap_irq_q <= 1'b0;
      chan_irq_q <= '0;
      wake_q     <= 1'b0;
    end else begin
      ext_oe_q   <= PORTD6_DIRECTION &
                    (ctrl_q[bpt_pkg::CTRL_PS_HI:0] != bpt_pkg::PS_EXT);
      wrap_irq_q <= ctrl_q[bpt_pkg::CTRL_WRAP_FLAG]
                  & ctrl_q[bpt_pkg::CTRL_WRAP_IE];
      for (int i = 0; i < N; i++)
        chan_irq_q[i] <= ch_ctrl_q[i][bpt_pkg::CH_FLAG]
                       & ch_ctrl_q[i][bpt_pkg::CH_IE]
                       & ~(i % 2 == 1 && linked[i/2]);
      wake_q <= WAIT_MODE & (wrap_irq_q | (|chan_irq_q));
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY  = wready_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;
  assign EXT_PIN_OE    = ext_oe_q;
  assign WRAP_IRQ      = wrap_irq_q;
  assign CHAN_IRQ      = chan_irq_q;
  assign WAKE_REQ      = wake_q;
endmodule // bpt_top

// file: bench/bpt_load.sv
// Purpose: Load on the six channel pins; times pulses.
// Assumes: Pull-down on each pin.
// Notes:   Lengths latch at each rising edge.
`timescale 1ns/1ps
module bpt_load (
  // Clock
  input  wire logic       clk,
  // Pins
  input  wire logic [5:0] pin,
  input  wire logic [5:0] oe,
  // Levels and lengths
  output logic      [5:0] lvl,
  output int              hi_len [6],
  output int              per_len [6]
);
  logic [5:0] lvl_q = 6'h00;
  int         hi_c [6];
  int         per_c [6];
  // Released pins fall to the pull-down
  assign lvl = pin & oe;
  // Negedge sampling keeps clear of pin updates
  always @(negedge clk) begin
    lvl_q <= lvl;
    for (int i = 0; i < 6; i++) begin
      per_c[i] <= (lvl[i] && !lvl_q[i]) ? 1 : per_c[i] + 1;
      hi_c[i]  <= (lvl[i] && !lvl_q[i]) ? 1 : hi_c[i] + lvl[i];
      if (lvl[i] && !lvl_q[i]) begin
        hi_len[i]  <= hi_c[i];
        per_len[i] <= per_c[i];
      end
    end
  end
endmodule // bpt_load

// file: bench/bpt_assertions.sv
// Purpose: Port checks on the timer.
// Assumes: Bound to the top module.
// Notes:   Pin checks assume no writes in stop.
`timescale 1ns/1ps
module bpt_assertions (
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        SRST,
  // Bus answers
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  // System and pins
  input wire logic        WAIT_MODE,
  input wire logic        STOP_MODE,
  input wire logic        BREAK_ACTIVE,
  input wire logic        PORTD6_DIRECTION,
  input wire logic        EXT_PIN_OE,
  input wire logic [5:0]  CHAN_PIN_OUT,
  input wire logic        WRAP_IRQ,
  input wire logic [5:0]  CHAN_IRQ,
  input wire logic        WAKE_REQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  // Answers stand until taken
  b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("B dropped");
  r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("R dropped");
  // Locked registers refuse; error reads return zero; wake needs wait mode and a request
  wait_refuse_a: assert property (
    $rose(S_AXI_BVALID) && $past(WAIT_MODE)
    |-> S_AXI_BRESP == 2'h2) else $error("wait write taken");
  err_zero_a: assert property (
    S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0)
    else $error("error read data");
  wake_cause_a: assert property (WAKE_REQ |-> $past(WAIT_MODE) &&
    ($past(WRAP_IRQ) || $past(CHAN_IRQ) != 6'h00)) else $error("wake");
  // Two samples of margin for the tick pipeline
  stop_freeze_a: assert property ($past(STOP_MODE, 2) &&
    $past(STOP_MODE) && STOP_MODE |-> $stable(CHAN_PIN_OUT))
    else $error("pins moved in stop");
  brk_freeze_a: assert property ($past(BREAK_ACTIVE, 2) &&
    $past(BREAK_ACTIVE) && BREAK_ACTIVE |-> $stable(CHAN_PIN_OUT))
    else $error("pins moved in break");
  ext_oe_a: assert property (EXT_PIN_OE |->
    $past(PORTD6_DIRECTION)) else $error("clock pin driven");
  cover property (WRAP_IRQ);
  cover property (WAKE_REQ);
  cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
endmodule // bpt_assertions
bind bpt_top bpt_assertions u_chk (.*);

// file: bench/buffered_pwm_timer_channels_tb_top.sv
// Purpose: Self-checking bench for the timer.
// Assumes: Bus answers checked off one queue.
// Notes:   Pulse lengths come from the load.
`timescale 1ns/1ps
module buffered_pwm_timer_channels_tb_top;
  logic        clk = 1'b0, SRST = 1'b1, WAIT_MODE = 1'b0;
  logic        STOP_MODE = 1'b0, BREAK_ACTIVE = 1'b0;
  logic        BREAK_CLEAR_ALLOW = 1'b0, PORTD6_DIRECTION = 1'b1;
  logic        EXT_COUNT_CLOCK = 1'b0, S_AXI_AWVALID = 1'b0;
  logic        S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic        S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB = 4'hF;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic        S_AXI_ARREADY, S_AXI_RVALID, EXT_PIN_OE;
  logic        WRAP_IRQ, WAKE_REQ, pa, pw;
  logic [5:0]  CHAN_PIN_OUT, CHAN_PIN_OE, CHAN_IRQ, lvl;
  logic [33:0] exp_q [$];
  logic [2:0]  ecnt = 3'h0;
  int          hi_len [6], per_len [6], m, w, sc, z;
  int          miscompares = 0, comparisons = 0;
  bpt_top DUT (.*, .CLK_SYS(clk));
  bpt_load u_load (.clk(clk), .pin(CHAN_PIN_OUT), .oe(CHAN_PIN_OE),
    .lvl(lvl), .hi_len(hi_len), .per_len(per_len));
  // 25 MHz bus clock
  initial begin
    forever #20 clk = ~clk;
  end
  // External count clock at bus over 8
  always @(posedge clk) begin
    ecnt <= ecnt + 3'h1;
    EXT_COUNT_CLOCK <= ecnt[2];
  end
  task automatic chk(input string n, input logic [33:0] s, e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // Write; each channel dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge clk);
    exp_q.push_back({r, 32'h0});
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    do begin
      @(negedge clk);
      pa = pa && !S_AXI_AWREADY;
      pw = pw && !S_AXI_WREADY;
      @(posedge clk);
      S_AXI_AWVALID <= pa;
      S_AXI_WVALID <= pw;
    end while (pa || pw);
    do @(negedge clk); while (!S_AXI_BVALID);
    @(posedge clk);
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(negedge clk); while (!S_AXI_ARREADY);
    @(posedge clk);
    S_AXI_ARVALID <= 1'b0;
    do @(negedge clk); while (!S_AXI_RVALID);
    @(posedge clk);
    S_AXI_RREADY <= 1'b0;
  endtask
  // Each bus answer takes the oldest note
  always @(negedge clk) begin
    if (S_AXI_BVALID && S_AXI_BREADY)
      chk("bresp", {S_AXI_BRESP, 32'h0}, exp_q.pop_front());
    if (S_AXI_RVALID && S_AXI_RREADY)
      chk("read", {S_AXI_RRESP, S_AXI_RDATA}, exp_q.pop_front());
  end
  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h016DBC21));
    m = 8 + $urandom % 8;
    w = 1 + $urandom % 4;
    repeat (8) @(posedge clk);
    SRST <= 1'b0;
    rd(8'h00, {2'h0, 32'h20});
    rd(8'h7C, {2'h2, 32'h0});
    wr(8'h00, 32'h30, 2'h0);
    rd(8'h00, {2'h0, 32'h20});
    wr(8'h08, m, 2'h0);
    wr(8'h14, w, 2'h0);
    wr(8'h10, 32'h1A, 2'h0);
    for (int n = 0; n < 8; n++) begin
      sc = (n == 7) ? 8 : 1 << n;
      wr(8'h00, n, 2'h0);
      repeat (3 * (m + 1) * sc + 20) @(negedge clk);
      chk("period", per_len[0], (m + 1) * sc);
      chk("width", hi_len[0], (w + 1) * sc);
      chk("ext oe", EXT_PIN_OE, n != 7);
    end
    wr(8'h00, 32'h0, 2'h0);
    for (int k = 0; k < 2; k++) begin
      wr(8'h10, k ? 32'h5B : 32'h18, 2'h0);
      repeat (m + 4) @(negedge clk);
      z = 0;
      repeat (2 * m) begin
        @(negedge clk);
        z += lvl[0];
      end
      chk("duty", z, k * 2 * m);
    end
    chk("chan irq", CHAN_IRQ, 6'h01);
    wr(8'h24, w, 2'h0);
    wr(8'h28, 32'h1A, 2'h0);
    wr(8'h20, 32'h3A, 2'h0);
    wr(8'h2C, w + 2, 2'h0);
    rd(8'h28, {2'h0, 32'h0});
    repeat (3 * m + 9) @(negedge clk);
    chk("odd oe", CHAN_PIN_OE[3], 1'b0);
    chk("odd pair", hi_len[2], w + 3);
    wr(8'h24, w, 2'h0);
    repeat (3 * m + 9) @(negedge clk);
    chk("even pair", hi_len[2], w + 1);
    wr(8'h00, 32'h40, 2'h0);
    repeat (m + 4) @(negedge clk);
    chk("wrap irq", WRAP_IRQ, 1'b1);
    wr(8'h00, 32'h60, 2'h0);
    rd(8'h00, {2'h0, 32'hE0});
    BREAK_ACTIVE <= 1'b1;
    wr(8'h00, 32'h60, 2'h0);
    rd(8'h00, {2'h0, 32'hE0});
    BREAK_ACTIVE <= 1'b0;
    wr(8'h00, 32'h60, 2'h0);
    rd(8'h00, {2'h0, 32'h60});
    BREAK_ACTIVE <= 1'b1;
    BREAK_CLEAR_ALLOW <= 1'b1;
    rd(8'h10, {2'h0, 32'hDB});
    wr(8'h10, 32'h5B, 2'h0);
    BREAK_ACTIVE <= 1'b0;
    BREAK_CLEAR_ALLOW <= 1'b0;
    rd(8'h10, {2'h0, 32'h5B});
    wr(8'h00, 32'h40, 2'h0);
    WAIT_MODE <= 1'b1;
    repeat (m + 4) @(negedge clk);
    chk("wake", WAKE_REQ, 1'b1);
    wr(8'h08, 32'h0, 2'h2);
    rd(8'h08, {2'h2, 32'h0});
    WAIT_MODE <= 1'b0;
    STOP_MODE <= 1'b1;
    repeat (4 * m) @(posedge clk);
    STOP_MODE <= 1'b0;
    give_verdict;
  end
  // Cut a hang short
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    give_verdict;
  end
endmodule // buffered_pwm_timer_channels_tb_top
